// *** rtl/lp_status_pkg.sv ***
// Shared constants and carrier types for the line printer status and handshake block
package lp_status_pkg;

  // Avalon register byte offsets
  localparam logic [3:0] STATUS_OFFSET   = 4'h0;  // Host status word, read only
  localparam logic [3:0] COMMAND_OFFSET  = 4'h4;  // Command strobes, write only
  localparam logic [3:0] DATA_OFFSET     = 4'h8;  // Seven-bit line count or print data
  localparam logic [3:0] IRQ_STAT_OFFSET = 4'hc;  // Sticky event bits, cleared by read

  // Status word bit positions (bit 00 is the word's most significant bit)
  localparam int STATUS_W   = 16;
  localparam int BIT_ERROR  = 15;   // Status bit 00
  localparam int BIT_INOP   = 12;   // Status bit 03
  localparam int BIT_BUSY   = 8;    // Status bit 07
  localparam int BIT_DRDY   = 7;    // Status bit 08
  localparam int BIT_PLOW   = 6;    // Status bit 09
  localparam int BIT_FORM   = 5;    // Status bit 10
  localparam int BIT_HOLD   = 3;    // Status bit 12

  // Command register bit positions
  localparam int CMD_PAPER_FEED = 0;  // Control command: paper feed only
  localparam int CMD_TRANSFER   = 1;  // Transfer initiate: feed then print
  localparam int CMD_TERMINATE  = 2;  // Terminate
  localparam int CMD_OUT_WORD   = 3;  // Output data word

  // Interrupt event bit positions and layout width
  localparam int EVT_W        = 4;
  localparam int EVT_SERVICE  = 0;  // Service interrupt
  localparam int EVT_DATA_REQ = 1;  // Data request
  localparam int EVT_FORM     = 2;  // Bottom of form reached
  localparam int EVT_INOP     = 3;  // Printer went inoperable

  // Reset values
  localparam logic [6:0]       DATA_RESET = 7'h00;
  localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;

  // Timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int READY_PULSE_NS = 200;
  localparam int READY_PULSE_CYC =
    (READY_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 : (READY_PULSE_NS / CLK_PERIOD_NS);
  localparam logic [3:0] STROBE_COUNT = 4'h4;  // Strobe fires at this count
  localparam logic [3:0] STROBE_END   = 4'h8;  // Word transfer finishes here

  // Printer input pins travel together
  typedef struct packed {
    logic form_channel_mark;
    logic line_advance_strobe;
    logic run_button_pressed;
    logic power_on;
    logic printer_ready_in;
    logic send_data_in;
    logic paper_low_in;
  } printer_in_t;

  // Printer output pins travel together
  typedef struct packed {
    logic       paper_feed_out;
    logic       print_out;
    logic       printer_strobe_out;
    logic [6:0] data;
  } printer_out_t;

endpackage : lp_status_pkg

// *** rtl/ready_pulse_gen.sv ***
// Single-shot pulse generator fired on a rising condition
`timescale 1ns/1ns
`default_nettype none
module ready_pulse_gen
  import lp_status_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic trigger,
  output logic      pulse
);

  logic [2:0] count_reg;   // Cycles of pulse left
  logic [2:0] count_next;
  logic       trig_reg;    // Last trigger level for edge detect
  logic       trig_next;

  // Load the width on a rising trigger, then count down
  always_comb
  begin
    trig_next  = trigger;
    count_next = count_reg;
    if (trigger && !trig_reg)
    begin
      count_next = 3'(READY_PULSE_CYC);
    end
    else if (count_reg != 3'h0)
    begin
      count_next = count_reg - 3'h1;
    end
  end

  // Register state
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      count_reg <= 3'h0;
      trig_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      count_reg <= count_next;
      trig_reg  <= trig_next;
    end
  end

  assign pulse = (count_reg != 3'h0);

endmodule : ready_pulse_gen
`default_nettype wire

// *** rtl/line_printer_status_handshake.sv ***
// Line printer controller status, command handshake and register slave
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Form flag sets on channel mark plus strobe
// - Strobe without channel mark clears form flag
// - Bottom of form shows on status bit 10
// - Powered but stopped holds command until run
// - Hold condition shows on status bit 12
// - Power off flags inoperable on bit 03
// - Operable means power on, gates feed and transfer commands
// - Status bit 00 is error, active low
// - Ready while running fires 200 ns pulse
// - Paper low shows on status bit 09
// - Busy on bit 07, data ready low bit 08
// - Terminate while idle sets service interrupt
// - Drive feed, print, strobe and seven data lines
// - Accept command, set busy only when operable
// - Strobe at count four after output word
module line_printer_status_handshake
  import lp_status_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire printer_in_t  printer_in,
  output printer_out_t      printer_out,
  input  wire logic [3:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  output logic              irq
);

  // Pin synchronisers: first stage read only by second stage
  printer_in_t sync1_reg;
  printer_in_t pins;        // Second stage, safe to use

  // Decoded printer conditions
  logic operable;           // Power on
  logic hold_cond;          // Powered but stopped
  logic ready_trig;         // Ready while running
  logic ready_pulse;        // Single-shot output

  // Control state
  logic       form_reg,    form_next;
  logic       busy_reg,    busy_next;
  logic       feed_reg,    feed_next;
  logic       print_reg,   print_next;
  logic       xfer_reg,    xfer_next;     // Transfer initiate awaiting print phase
  logic       pend_reg,    pend_next;     // Command stored during hold
  logic [3:0] pend_cmd_reg, pend_cmd_next;
  logic       drq_reg,     drq_next;      // Data request, drives data ready
  logic       cnt_en_reg,  cnt_en_next;   // Strobe counter running
  logic [3:0] cnt_reg,     cnt_next;
  logic       strobe_reg,  strobe_next;
  logic [6:0] data_reg,    data_next;
  logic       send_d_reg,  send_d_next;   // Send data one cycle back, for its edges
  logic       form_d_reg,  form_d_next;
  logic       oper_d_reg,  oper_d_next;

  // Interrupt and bus state
  logic [EVT_W-1:0] evt_reg,  evt_next;    // Sticky events
  logic [EVT_W-1:0] mask_reg, mask_next;   // Enables
  logic [31:0]      rdata_reg, rdata_next;
  logic             wait_reg, wait_next;   // Waitrequest, low for one cycle per access
  logic             irq_reg,  irq_next;
  logic [EVT_W-1:0] evt_set;

  // Bus access decode helper used for the command, data and interrupt registers; status reads decode through the case below
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
    hit = (addr == off);
  endfunction : hit

  // Build the host status word
  function automatic logic [STATUS_W-1:0] status_word(
    input logic oper, input logic busy, input logic drq,
    input logic plow, input logic form, input logic hold);
    logic [STATUS_W-1:0] w;
    w = '0;
    w[BIT_ERROR] = oper;    // Low when in error
    w[BIT_INOP]  = !oper;
    w[BIT_BUSY]  = busy;
    w[BIT_DRDY]  = !drq;
    w[BIT_PLOW]  = plow;
    w[BIT_FORM]  = form;
    w[BIT_HOLD]  = hold;
    status_word = w;
  endfunction : status_word

  // Two flip-flop synchroniser on all printer pins
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sync1_reg <= '0;
      pins      <= '0;
    end
    else if (clk_en)
    begin
      sync1_reg <= printer_in;
      pins      <= sync1_reg;
    end
  end

  assign operable   = pins.power_on;
  assign hold_cond  = pins.power_on && !pins.run_button_pressed;
  // Printer owns ready; rising edge ends its operation
  assign ready_trig = pins.printer_ready_in && pins.run_button_pressed;

  ready_pulse_gen u_ready_pulse (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .trigger (ready_trig),
    .pulse   (ready_pulse)
  );

  // Command, handshake and strobe sequencing
  always_comb
  begin
    logic       wr, rd, terminate;
    logic [3:0] cmd;
    logic       go;
    go        = 1'b0;
    wr        = avs_write && !wait_reg;
    rd        = avs_read && !wait_reg;
    cmd       = (wr && hit(avs_address, COMMAND_OFFSET)) ? avs_writedata[3:0] : 4'h0;
    terminate = cmd[CMD_TERMINATE];
    form_next    = form_reg;
    busy_next    = busy_reg;
    feed_next    = feed_reg;
    print_next   = print_reg;
    xfer_next    = xfer_reg;
    pend_next    = pend_reg;
    pend_cmd_next = pend_cmd_reg;
    drq_next     = drq_reg;
    cnt_en_next  = cnt_en_reg;
    cnt_next     = cnt_reg;
    strobe_next  = 1'b0;
    data_next    = data_reg;
    send_d_next   = pins.send_data_in;
    form_d_next  = form_reg;
    oper_d_next  = operable;
    evt_set      = '0;

    // Bottom of form tracking
    if (pins.line_advance_strobe)
    begin
      form_next = pins.form_channel_mark;
    end

    // Data buffer written from the bus
    if (wr && hit(avs_address, DATA_OFFSET))
    begin
      data_next = avs_writedata[6:0];
    end

    // Stored command waits while holding, released when run pressed
    if (pend_reg && !hold_cond)
    begin
      go            = 1'b1;
      pend_next     = 1'b0;
    end

    // New feed or transfer command
    if (cmd[CMD_PAPER_FEED] || cmd[CMD_TRANSFER])
    begin
      if (!operable)
      begin
        evt_set[EVT_SERVICE] = 1'b1;        // Inoperable command interrupts
      end
      else if (hold_cond)
      begin
        pend_next     = 1'b1;
        pend_cmd_next = cmd;
      end
      else
      begin
        busy_next = 1'b1;
        feed_next = 1'b1;
        xfer_next = cmd[CMD_TRANSFER];
      end
    end
    if (go && operable)
    begin
      busy_next = 1'b1;
      feed_next = 1'b1;
      xfer_next = pend_cmd_reg[CMD_TRANSFER];
    end

    // Feed ends on the falling edge of send data; the edge is used because the
    // synchroniser delay keeps send data low for the first cycles after feed rises
    if (feed_reg && send_d_reg && !pins.send_data_in)
    begin
      feed_next   = 1'b0;
      cnt_en_next = 1'b0;
      cnt_next    = 4'h0;
    end

    // Printer ready pulse completes a cycle (not while holding); the pulse lasts two
    // cycles, so a running print phase keeps the second cycle from ending the command
    if (ready_pulse && busy_reg && !feed_reg && !print_reg && !hold_cond)
    begin
      if (xfer_reg)
      begin
        xfer_next  = 1'b0;
        print_next = 1'b1;
        drq_next   = 1'b1;                  // First data request
        evt_set[EVT_DATA_REQ] = 1'b1;
      end
      else
      begin
        busy_next = 1'b0;
        evt_set[EVT_SERVICE] = 1'b1;
      end
    end

    // Output word starts the strobe counter
    if (cmd[CMD_OUT_WORD])
    begin
      drq_next    = 1'b0;
      cnt_en_next = 1'b1;
      cnt_next    = 4'h0;
    end
    // Only the rising edge of send data starts a line count, so one feed strobes once
    else if (feed_reg && pins.send_data_in && !send_d_reg && !cnt_en_reg && cnt_reg == 4'h0)
    begin
      cnt_en_next = 1'b1;                   // Line count transfer
    end

    // Count while command and send data active
    if (cnt_en_reg && (print_reg || feed_reg) && pins.send_data_in)
    begin
      cnt_next = cnt_reg + 4'h1;
      if (cnt_next == STROBE_COUNT)
      begin
        strobe_next = 1'b1;
      end
      if (cnt_next == STROBE_END)
      begin
        cnt_en_next = 1'b0;
        cnt_next    = 4'h0;
        if (print_reg)
        begin
          drq_next = 1'b1;
          evt_set[EVT_DATA_REQ] = 1'b1;
        end
      end
    end

    // Send data falling means the printer buffer is full: the print phase ends
    if (print_reg && send_d_reg && !pins.send_data_in)
    begin
      print_next  = 1'b0;
      cnt_en_next = 1'b0;
      cnt_next    = 4'h0;
    end

    // Terminate stops printing or interrupts when idle
    if (terminate)
    begin
      if (!busy_reg)
      begin
        evt_set[EVT_SERVICE] = 1'b1;
      end
      print_next  = 1'b0;
      drq_next    = 1'b0;
      busy_next   = 1'b0;
      cnt_en_next = 1'b0;
      cnt_next    = 4'h0;
      xfer_next   = 1'b0;
    end

    if (form_reg && !form_d_reg)
    begin
      evt_set[EVT_FORM] = 1'b1;
    end
    if (!operable && oper_d_reg)
    begin
      evt_set[EVT_INOP] = 1'b1;
    end

    // Sticky events: set wins over read clear
    evt_next = evt_reg;
    if (rd && hit(avs_address, IRQ_STAT_OFFSET))
    begin
      // Clear only what the read reported, so an event landing mid-access survives
      evt_next = evt_reg & ~rdata_reg[EVT_W-1:0];
    end
    evt_next = evt_next | evt_set;

    mask_next = mask_reg;
    if (wr && hit(avs_address, IRQ_STAT_OFFSET))
    begin
      mask_next = avs_writedata[EVT_W-1:0];
    end
    irq_next = |(evt_next & mask_next);

    // Bus answer: one wait cycle then accept
    wait_next  = !((avs_read || avs_write) && wait_reg);
    rdata_next = rdata_reg;
    if (avs_read && wait_reg)
    begin
      unique case (avs_address)
        STATUS_OFFSET:
          rdata_next = {16'h0000, status_word(operable, busy_reg, drq_reg,
                        pins.paper_low_in, form_reg, hold_cond)};
        DATA_OFFSET:     rdata_next = {25'h0000000, data_reg};
        IRQ_STAT_OFFSET: rdata_next = {24'h000000, mask_reg, evt_reg};
        default:         rdata_next = 32'h00000000;
      endcase
    end
  end

  // Register all control state
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      form_reg     <= 1'b0;
      busy_reg     <= 1'b0;
      feed_reg     <= 1'b0;
      print_reg    <= 1'b0;
      xfer_reg     <= 1'b0;
      pend_reg     <= 1'b0;
      pend_cmd_reg <= 4'h0;
      drq_reg      <= 1'b0;
      cnt_en_reg   <= 1'b0;
      cnt_reg      <= 4'h0;
      strobe_reg   <= 1'b0;
      send_d_reg   <= 1'b0;
      form_d_reg   <= 1'b0;
      oper_d_reg   <= 1'b0;
      data_reg     <= DATA_RESET;
      evt_reg      <= '0;
      mask_reg     <= MASK_RESET;
      rdata_reg    <= 32'h00000000;
      wait_reg     <= 1'b1;
      irq_reg      <= 1'b0;
    end
    else if (clk_en)
    begin
      form_reg     <= form_next;
      busy_reg     <= busy_next;
      feed_reg     <= feed_next;
      print_reg    <= print_next;
      xfer_reg     <= xfer_next;
      pend_reg     <= pend_next;
      pend_cmd_reg <= pend_cmd_next;
      drq_reg      <= drq_next;
      cnt_en_reg   <= cnt_en_next;
      cnt_reg      <= cnt_next;
      strobe_reg   <= strobe_next;
      send_d_reg   <= send_d_next;
      form_d_reg   <= form_d_next;
      oper_d_reg   <= oper_d_next;
      data_reg     <= data_next;
      evt_reg      <= evt_next;
      mask_reg     <= mask_next;
      rdata_reg    <= rdata_next;
      wait_reg     <= wait_next;
      irq_reg      <= irq_next;
    end
  end

  // Outputs straight from flip-flops
  assign printer_out.paper_feed_out     = feed_reg;
  assign printer_out.print_out          = print_reg;
  assign printer_out.printer_strobe_out = strobe_reg;
  assign printer_out.data               = data_reg;
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign irq             = irq_reg;

endmodule : line_printer_status_handshake
`default_nettype wire

// *** tb/lp_status_assertions.sv ***
// Port checker for the printer status block
`timescale 1ns/1ns
`default_nettype none
module lp_status_checker
  import lp_status_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire printer_in_t printer_in,
  input wire printer_out_t printer_out,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Status read accepted this cycle
  wire logic st_rd;
  assign st_rd = avs_read && !avs_waitrequest && avs_address == STATUS_OFFSET;

  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0) else $error("hole");
  a_inop_status: assert property (st_rd && !printer_in.power_on
    && !$past(printer_in.power_on, 6) |-> avs_readdata[BIT_INOP]
    && !avs_readdata[BIT_ERROR]) else $error("inoperable bits");
  a_hold_status: assert property (st_rd && printer_in.power_on
    && !printer_in.run_button_pressed && !$past(printer_in.run_button_pressed, 6)
    |-> avs_readdata[BIT_HOLD]) else $error("hold bit");
  a_feed_gated: assert property ($rose(printer_out.paper_feed_out)
    |-> $past(printer_in.power_on, 3) && $past(printer_in.run_button_pressed, 3))
    else $error("feed while not running");
  a_strobe_send: assert property ($rose(printer_out.printer_strobe_out)
    |-> $past(printer_in.send_data_in, 3)) else $error("strobe early");
  a_strobe_pulse: assert property (printer_out.printer_strobe_out
    |=> !printer_out.printer_strobe_out) else $error("strobe long");
  a_clear_outputs: assert property (disable iff (1'b0) !reset_n && clk_en
    |=> avs_waitrequest && !irq && printer_out == '0) else $error("clear");

  c_feed: cover property (printer_out.paper_feed_out);
  c_print_strobe: cover property (printer_out.printer_strobe_out && printer_out.print_out);
  c_irq: cover property (irq);
endmodule : lp_status_checker

bind line_printer_status_handshake lp_status_checker chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .clk_en(clk_en), .printer_in(printer_in),
  .printer_out(printer_out), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
`default_nettype wire

// *** tb/printer_model.sv ***
// Behavioural printer mechanism with form channel
`timescale 1ns/1ns
`default_nettype none
module printer_model
  import lp_status_pkg::*;
(
  input wire logic   sys_clk,
  input wire logic   reset_n,
  input wire logic   power,     // Mains on
  input wire logic   run,       // Run button held
  input wire logic   low,       // Paper nearly out
  input wire logic   chan,      // Channel punched here
  input wire printer_out_t pout,
  output printer_in_t pin,
  output int         strobes,   // Strobes taken
  output logic [6:0] last_data  // Word at last strobe
);
  logic       sent;  // Feed word taken, no more wanted
  logic [2:0] cool;  // Mechanism still moving
  logic       adv;   // One line advance pulse
  wire logic  cmd;
  assign cmd = pout.paper_feed_out | pout.print_out;
  // Mechanism state; the print buffer never fills, so only terminate ends print
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sent <= 1'b0;
      cool <= 3'h0;
      adv <= 1'b0;
      strobes <= 0;
      last_data <= 7'h00;
    end
    else
    begin
      adv <= pout.printer_strobe_out & pout.paper_feed_out;
      if (pout.printer_strobe_out)
      begin
        strobes <= strobes + 1;
        last_data <= pout.data;
        cool <= 3'h4;
        sent <= pout.paper_feed_out;
      end
      else
      begin
        if (!cmd)
          sent <= 1'b0;
        if (cool != 3'h0)
          cool <= cool - 3'h1;
      end
    end
  end
  assign pin.form_channel_mark = chan;
  assign pin.line_advance_strobe = adv;
  assign pin.run_button_pressed = run;
  assign pin.power_on = power;
  assign pin.printer_ready_in = power && !cmd && cool == 3'h0;
  assign pin.send_data_in = cmd && !sent;
  assign pin.paper_low_in = low;
endmodule : printer_model
`default_nettype wire

// *** tb/line_printer_status_handshake_bench.sv ***
// Bench for the printer status block over its register bus
`timescale 1ns/1ns
`default_nettype none
module line_printer_status_handshake_bench
  import lp_status_pkg::*;
;
  logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, irq;
  logic power, run, low, chan;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  printer_in_t pin;
  printer_out_t pout;
  int errors, cmp_count;

  // Free running 10 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  line_printer_status_handshake uut (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(1'b1), .printer_in(pin), .printer_out(pout),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  printer_model mdl (.sys_clk(sys_clk), .reset_n(reset_n), .power(power),
    .run(run), .low(low), .chan(chan), .pout(pout), .pin(pin),
    .strobes(), .last_data());

  // One bus access; holds the request until waitrequest is sampled low at a rising
  // edge, takes read data at that edge and releases; only the watchdog ends a wait
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd_check(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd_check

  // Poll status until one bit reaches a level, bounded
  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, STATUS_OFFSET, 32'h0);
      n++;
    end
    while (q[b] !== v && n < 100);
    check({31'h0, q[b]}, {31'h0, v});
  endtask : wait_bit

  task automatic issue(input logic [6:0] d, input logic [3:0] c);
    bus(1'b1, DATA_OFFSET, {25'h0, d});
    bus(1'b1, COMMAND_OFFSET, {28'h0, c});
  endtask : issue

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // Hang guard, over fifty times the expected run
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    final_report();
  end

  initial
  begin
    errors = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    {power, run, low, chan} = 4'b1100;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd_check(STATUS_OFFSET, 32'h8080);
    rd_check(IRQ_STAT_OFFSET, 32'h0);
    rd_check(DATA_OFFSET, 32'h0);
    rd_check(4'h3, 32'h0);
    $display("test reset done");
    // Stopped printer stores the feed until run
    run <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd_check(STATUS_OFFSET, 32'h8088);
    issue(7'h05, 4'h1);
    repeat (20) @(posedge sys_clk);
    check(32'(mdl.strobes), 32'h0);
    run <= 1'b1;
    wait_bit(BIT_BUSY, 1'b1);
    wait_bit(BIT_BUSY, 1'b0);
    check(32'(mdl.strobes), 32'h1);
    check({25'h0, mdl.last_data}, 32'h5);
    rd_check(IRQ_STAT_OFFSET, 32'h1);
    $display("test hold done");
    // Feed over the channel mark, then past it
    for (int i = 1; i >= 0; i--)
    begin
      chan <= i[0];
      issue(7'h03, 4'h1);
      wait_bit(BIT_BUSY, 1'b1);
      wait_bit(BIT_BUSY, 1'b0);
      rd_check(STATUS_OFFSET, i ? 32'h80a0 : 32'h8080);
      rd_check(IRQ_STAT_OFFSET, i ? 32'h5 : 32'h1);
    end
    $display("test form done");
    // Terminate while idle, through the mask
    bus(1'b1, IRQ_STAT_OFFSET, 32'h1);
    bus(1'b1, COMMAND_OFFSET, 32'h4);
    repeat (3) @(negedge sys_clk);
    check({31'h0, irq}, 32'h1);
    rd_check(IRQ_STAT_OFFSET, 32'h11);
    repeat (2) @(negedge sys_clk);
    check({31'h0, irq}, 32'h0);
    $display("test terminate done");
    // Paper low, then power off refusing a command
    low <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd_check(STATUS_OFFSET, 32'h80c0);
    low <= 1'b0;
    power <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd_check(STATUS_OFFSET, 32'h1080);
    bus(1'b1, COMMAND_OFFSET, 32'h1);
    repeat (6) @(posedge sys_clk);
    rd_check(STATUS_OFFSET, 32'h1080);
    rd_check(IRQ_STAT_OFFSET, 32'h19);
    $display("test power done");
    // Transfer: feed, data request, one word, terminate
    power <= 1'b1;
    repeat (6) @(posedge sys_clk);
    issue(7'h01, 4'h2);
    wait_bit(BIT_DRDY, 1'b0);
    rd_check(STATUS_OFFSET, 32'h8100);
    issue(7'h2a, 4'h8);
    repeat (16) @(posedge sys_clk);
    check(32'(mdl.strobes), 32'h5);
    check({25'h0, mdl.last_data}, 32'h2a);
    bus(1'b1, COMMAND_OFFSET, 32'h4);
    wait_bit(BIT_BUSY, 1'b0);
    @(negedge sys_clk);
    check({31'h0, pout.print_out}, 32'h0);
    $display("test transfer done");
    final_report();
  end
endmodule : line_printer_status_handshake_bench
`default_nettype wire
